/* File: cfg_latch_pkg.sv */
// constants, field layout and carrier types for the upper configuration latch
// assumes one 20 MHz clock domain and an AXI4-Lite register bus
package cfg_latch_pkg;

  localparam int PAD_W = 29;
  localparam int SYNC_W = PAD_W + 2;

  // pad bit positions of each latched field
  localparam int EXT_DIV_LSB = 15;
  localparam int GFX_DIV_LSB = 18;
  localparam int SMEM_DIV_LSB = 20;
  localparam int B1_ASYNC_BIT = 22;
  localparam int B2_ASYNC_BIT = 23;
  localparam int ONCHIP_ASYNC_BIT = 24;
  localparam int PASSTHRU_BIT = 25;
  localparam int B1_BURST_BIT = 26;
  localparam int B2_BURST_BIT = 27;
  localparam int ONCHIP_BURST_BIT = 28;
  localparam int EXT_DIV_W = 3;
  localparam int GFX_DIV_W = 2;
  localparam int SMEM_DIV_W = 2;

  typedef struct packed {
    logic onchip_bridge_burst_override;
    logic bridge2_burst_override;
    logic bridge1_burst_override;
    logic bridge_passthrough_force;
    logic onchip_bridge_async_force;
    logic bridge2_async_force;
    logic bridge1_async_force;
    logic [SMEM_DIV_W-1:0] static_mem_clk_div_sel;
    logic [GFX_DIV_W-1:0] gfx_clk_div_sel;
    logic [EXT_DIV_W-1:0] ext_bus_clk_div_sel;
  } cfg_t;

  localparam int CFG_W = $bits(cfg_t);

  // code n divides by n+1
  localparam logic [EXT_DIV_W-1:0] EXT_DIV_RST = 3'h1;
  localparam logic [GFX_DIV_W-1:0] GFX_DIV_RST = 2'h1;
  localparam logic [SMEM_DIV_W-1:0] SMEM_DIV_RST = 2'h1;
  localparam cfg_t CFG_RESET = '{
    onchip_bridge_burst_override: 1'h0,
    bridge2_burst_override: 1'h0,
    bridge1_burst_override: 1'h0,
    bridge_passthrough_force: 1'h0,
    onchip_bridge_async_force: 1'h0,
    bridge2_async_force: 1'h0,
    bridge1_async_force: 1'h0,
    static_mem_clk_div_sel: SMEM_DIV_RST,
    gfx_clk_div_sel: GFX_DIV_RST,
    ext_bus_clk_div_sel: EXT_DIV_RST
  };

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_CLEARED = 2'b01,
    ST_LOADED = 2'b10
  } cfg_state_t;

  // register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CONFIG = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h4;
  localparam logic [ADDR_W-1:0] REG_PADS = 4'h8;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'hC;

  localparam int CTRL_PAD_EN_BIT = 0;
  localparam int CTRL_SW_SAMPLE_BIT = 1;
  localparam logic CTRL_PAD_EN_RST = 1'h1;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_COUNT_LSB = 8;
  localparam int COUNT_W = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: cfg_latch_upper.sv */
// power-on configuration latch, upper field group, with AXI4-Lite access
// assumes pads are asynchronous and stay stable around the sampling edge
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
module cfg_latch_upper
  import cfg_latch_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [PAD_W-1:0] CONFIG_SOURCE_DATA_PORT,
  input wire logic CONFIG_SAMPLE_STROBE,
  input wire logic CONFIG_CLEAR_N,
  output cfg_t CFG,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP
);

  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  logic [PAD_W-1:0] pads;
  logic strobe_s;
  logic clear_n_s;
  logic strobe_prev;
  logic strobe_rise;
  logic pad_en;
  logic sw_sample;
  logic load;
  cfg_t cfg;
  cfg_t next_cfg;
  cfg_state_t state;
  cfg_state_t next_state;
  logic [COUNT_W-1:0] load_count;

  // pads, strobe and clear all cross through one synchroniser stage pair
  // clear travels inverted: the zero reset of the flops must not fake a clear after reset
  assign sync_in = {~CONFIG_CLEAR_N, CONFIG_SAMPLE_STROBE, CONFIG_SOURCE_DATA_PORT};

  cfg_sync2 #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .rst_val('0),
    .async_in(sync_in),
    .sync_out(sync_out)
  );

  assign pads = sync_out[PAD_W-1:0];
  assign strobe_s = sync_out[PAD_W];
  assign clear_n_s = !sync_out[PAD_W+1];

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      strobe_prev <= 1'h0;
    end else begin
      strobe_prev <= strobe_s;
    end
  end

  // pads went through the same two flops, so they line up with the edge
  assign strobe_rise = strobe_s && !strobe_prev;
  assign load = clear_n_s && ((strobe_rise && pad_en) || sw_sample);

  always_comb begin
    next_cfg = cfg;
    if (!clear_n_s) begin
      next_cfg = CFG_RESET;
    end else if (load) begin
      next_cfg.ext_bus_clk_div_sel = pads[EXT_DIV_LSB +: EXT_DIV_W];
      next_cfg.gfx_clk_div_sel = pads[GFX_DIV_LSB +: GFX_DIV_W];
      next_cfg.static_mem_clk_div_sel = pads[SMEM_DIV_LSB +: SMEM_DIV_W];
      next_cfg.bridge1_async_force = pads[B1_ASYNC_BIT];
      next_cfg.bridge2_async_force = pads[B2_ASYNC_BIT];
      next_cfg.onchip_bridge_async_force = pads[ONCHIP_ASYNC_BIT];
      next_cfg.bridge_passthrough_force = pads[PASSTHRU_BIT];
      next_cfg.bridge1_burst_override = pads[B1_BURST_BIT];
      next_cfg.bridge2_burst_override = pads[B2_BURST_BIT];
      next_cfg.onchip_bridge_burst_override = pads[ONCHIP_BURST_BIT];
    end
  end

  // holds otherwise: the pads double as a bus later and must not leak in
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg <= CFG_RESET;
    end else begin
      cfg <= next_cfg;
    end
  end

  assign CFG = cfg;

  always_comb begin
    next_state = state;
    case (state)
      ST_RESET: begin
        if (!clear_n_s) begin
          next_state = ST_CLEARED;
        end else if (load) begin
          next_state = ST_LOADED;
        end
      end
      ST_CLEARED: begin
        if (load) begin
          next_state = ST_LOADED;
        end
      end
      ST_LOADED: begin
        if (!clear_n_s) begin
          next_state = ST_CLEARED;
        end
      end
      default: begin
        next_state = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // wraps; software reads it only to see that a capture happened
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      load_count <= '0;
    end else if (!clear_n_s) begin
      load_count <= '0;
    end else if (load) begin
      load_count <= load_count + 1'b1;
    end
  end

  // ---- AXI4-Lite write path ----
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic wr_hit;

  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
  assign do_write = aw_held && w_held && !S_AXI_BVALID;
  assign wr_hit = (aw_addr == REG_CTRL);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_held <= 1'h0;
      aw_addr <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held <= 1'h1;
      aw_addr <= S_AXI_AWADDR;
    end else if (do_write) begin
      aw_held <= 1'h0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      w_held <= 1'h0;
      w_data <= '0;
      w_strb <= '0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held <= 1'h1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end else if (do_write) begin
      w_held <= 1'h0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_BVALID <= 1'h0;
      S_AXI_BRESP <= RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'h1;
      S_AXI_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'h0;
    end
  end

  // writes to any register other than the control register change nothing and answer SLVERR
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pad_en <= CTRL_PAD_EN_RST;
    end else if (do_write && wr_hit && w_strb[0]) begin
      pad_en <= w_data[CTRL_PAD_EN_BIT];
    end
  end

  // write-one pulse: a software capture without toggling the strobe pin
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sw_sample <= 1'h0;
    end else begin
      sw_sample <= do_write && wr_hit && w_strb[0] && w_data[CTRL_SW_SAMPLE_BIT];
    end
  end

  // ---- AXI4-Lite read path ----
  logic [31:0] rd_word;
  logic rd_ok;

  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_comb begin
    rd_word = '0;
    rd_ok = 1'h1;
    if (S_AXI_ARADDR == REG_CONFIG) begin
      rd_word[CFG_W-1:0] = cfg;
    end else if (S_AXI_ARADDR == REG_CTRL) begin
      rd_word[CTRL_PAD_EN_BIT] = pad_en;
    end else if (S_AXI_ARADDR == REG_PADS) begin
      rd_word[PAD_W-1:0] = pads;
    end else if (S_AXI_ARADDR == REG_STATUS) begin
      rd_word[STAT_STATE_LSB +: $bits(cfg_state_t)] = state;
      rd_word[STAT_COUNT_LSB +: COUNT_W] = load_count;
    end else begin
      rd_ok = 1'h0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'h0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'h1;
      S_AXI_RDATA <= rd_word;
      S_AXI_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'h0;
    end
  end

  logic unused_prot;
  assign unused_prot = ^{S_AXI_AWPROT, S_AXI_ARPROT, w_strb[3:1]};

endmodule // cfg_latch_upper

/* File: cfg_latch_upper_props.sv */
// checker for the upper configuration latch, bound to its top module
// assumes pads stay stable for 6 cycles after a strobe rise
module cfg_latch_upper_props
  import cfg_latch_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [PAD_W-1:0] CONFIG_SOURCE_DATA_PORT,
  input wire logic CONFIG_SAMPLE_STROBE,
  input wire logic CONFIG_CLEAR_N,
  input wire cfg_t CFG,
  input wire logic S_AXI_BVALID
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  wire s = CONFIG_SAMPLE_STROBE;
  wire c = CONFIG_CLEAR_N;
  wire [PAD_W-1:0] p = CONFIG_SOURCE_DATA_PORT;
  // sync delay is 3 edges, two more allowed for pin timing
  a_ext_load: assert property ($rose(s) && c |-> ##5 CFG.ext_bus_clk_div_sel == p[17:15])
    else $error("ext divide not loaded");
  a_gfx_load: assert property ($rose(s) && c |-> ##5 CFG.gfx_clk_div_sel == p[19:18])
    else $error("gfx divide not loaded");
  a_smem_load: assert property ($rose(s) && c |-> ##5 CFG.static_mem_clk_div_sel == p[21:20])
    else $error("smem divide not loaded");
  a_async_load: assert property ($rose(s) && c |-> ##5 {CFG.onchip_bridge_async_force,
    CFG.bridge2_async_force, CFG.bridge1_async_force} == p[24:22]) else $error("async flags not loaded");
  a_pass_load: assert property ($rose(s) && c |-> ##5 CFG.bridge_passthrough_force == p[25])
    else $error("pass-through not loaded");
  a_burst_load: assert property ($rose(s) && c |-> ##5 {CFG.onchip_bridge_burst_override,
    CFG.bridge2_burst_override, CFG.bridge1_burst_override} == p[28:26]) else $error("burst flags not loaded");
  a_clear_rst: assert property (!c [*6] |-> CFG == CFG_RESET)
    else $error("clear did not restore");
  a_hold_cfg: assert property ($changed(CFG) |-> $past(s, 2) || !$past(c, 2) || $past(S_AXI_BVALID))
    else $error("config changed unprompted");
endmodule // cfg_latch_upper_props

bind cfg_latch_upper cfg_latch_upper_props props (.REF_CLK, .RST_N, .CONFIG_SOURCE_DATA_PORT,
  .CONFIG_SAMPLE_STROBE, .CONFIG_CLEAR_N, .CFG, .S_AXI_BVALID);

/* File: cfg_pad_model.sv */
// board-side model: configuration pads, sample strobe and clear
// assumes it is clocked by the device clock; changes follow rising edges
module cfg_pad_model
  import cfg_latch_pkg::*;
(
  input wire logic clk,
  output logic [PAD_W-1:0] pads = '0,
  output logic strobe = 1'b0,
  output logic clear_n = 1'b1
);
  task automatic set_pads(input logic [PAD_W-1:0] v);
    @(posedge clk);
    pads <= v;
    repeat (4) @(posedge clk);
  endtask
  task automatic present(input logic [PAD_W-1:0] v);
    set_pads(v);
    strobe <= 1'b1;
    repeat (7) @(posedge clk);
    strobe <= 1'b0;
    // hold time over, so the old levels must not linger
    pads <= ~v;
    repeat (4) @(posedge clk);
  endtask
  task automatic set_clear(input logic lvl);
    @(posedge clk);
    clear_n <= lvl;
    repeat (6) @(posedge clk);
  endtask
endmodule // cfg_pad_model

/* File: cfg_sync2.sv */
// two-flop synchroniser for a vector of slow pad levels
// assumes each bit is static around the instant it is used
module cfg_sync2
  import cfg_latch_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] rst_val,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // reset loads zero into both stages; the rst_val tie-off at the instance is unused
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
    end else begin
      meta <= async_in;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_out <= '0;
    end else begin
      sync_out <= meta;
    end
  end

  logic unused_rst_val;
  assign unused_rst_val = ^rst_val;

endmodule // cfg_sync2

/* File: testbench.sv */
// self-checking bench for the upper configuration latch
// assumes the pad model and the bound checker are compiled with it
module testbench
  import cfg_latch_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic awr, wr, bv, arr, rv, strobe, clear_n;
  logic [ADDR_W-1:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rd;
  logic [3:0] ws = 4'hF;
  logic [2:0] prot = 3'h0;
  logic [1:0] bresp, rresp;
  logic [PAD_W-1:0] pads;
  cfg_t cfg;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  cfg_pad_model pm (.clk(clk), .pads(pads), .strobe(strobe), .clear_n(clear_n));
  cfg_latch_upper dut (.REF_CLK(clk), .RST_N(rst_n), .CONFIG_SOURCE_DATA_PORT(pads),
    .CONFIG_SAMPLE_STROBE(strobe), .CONFIG_CLEAR_N(clear_n), .CFG(cfg),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_AWPROT(prot),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_ARPROT(prot), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er,
      input logic [3:0] st);
    @(posedge clk);
    awa <= a;
    wd <= d;
    ws <= st;
    // protection bits are ignored by the block; a nonzero value shows that
    prot <= 3'h1;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (bv !== 1'b1);
    br <= 1'b0;
    chk("bresp", bresp, er);
  endtask
  task automatic axi_read(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rr <= 1'b0;
    chk("rresp", rresp, RESP_OKAY);
    chk("rdata", rd, exp);
  endtask
  function automatic cfg_t exp_of(input logic [PAD_W-1:0] v);
    cfg_t e;
    e.ext_bus_clk_div_sel = v[17:15];
    e.gfx_clk_div_sel = v[19:18];
    e.static_mem_clk_div_sel = v[21:20];
    e.bridge1_async_force = v[22];
    e.bridge2_async_force = v[23];
    e.onchip_bridge_async_force = v[24];
    e.bridge_passthrough_force = v[25];
    e.bridge1_burst_override = v[26];
    e.bridge2_burst_override = v[27];
    e.onchip_bridge_burst_override = v[28];
    return e;
  endfunction
  task automatic t_reset();
    chk("cfg reset", cfg, CFG_RESET);
    axi_read(REG_CONFIG, 32'(CFG_RESET));
    axi_write(REG_PADS, 32'h0, RESP_SLVERR, 4'hF);
    // byte lane 0 off: the control write must leave the pad enable alone
    axi_write(REG_CTRL, 32'h0, RESP_OKAY, 4'h0);
    axi_read(REG_CTRL, 32'h1);
  endtask
  // every divide code, flags in changing mixes; pads are scrambled after each strobe
  task automatic t_capture();
    logic [PAD_W-1:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {7'(7'h2A ^ (i * 19)), ~2'(i), 2'(i), 3'(i), {15{i[0]}}};
      pm.present(v);
      chk("cfg loaded", cfg, exp_of(v));
    end
  endtask
  task automatic t_soft();
    logic [PAD_W-1:0] v;
    v = 29'h0ABCDE5;
    pm.set_pads(v);
    // still the last pattern that t_capture latched
    chk("no strobe", cfg, exp_of(29'h0BCFFFFF));
    axi_read(REG_PADS, 32'(v));
    axi_write(REG_CTRL, 32'h3, RESP_OKAY, 4'hF);
    repeat (3) @(posedge clk);
    axi_read(REG_CONFIG, 32'(exp_of(v)));
  endtask
  task automatic t_clear();
    pm.set_clear(1'b0);
    chk("clear", cfg, CFG_RESET);
    pm.present(29'h1FFFFFFF);
    chk("clear wins", cfg, CFG_RESET);
    pm.set_clear(1'b1);
    chk("after clear", cfg, CFG_RESET);
    axi_read(REG_STATUS, 32'h1);
  endtask
  task automatic t_midreset();
    pm.present(29'h1FC3FFFF);
    chk("cfg set", cfg, exp_of(29'h1FC3FFFF));
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("cfg rst", cfg, CFG_RESET);
    rst_n <= 1'b1;
    axi_read(REG_STATUS, 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_capture();
    t_soft();
    t_clear();
    t_midreset();
    end_of_test();
  end
endmodule // testbench
